// ---- verif/sarseq_top_bench.sv ----
// self-checking bench for the sar converter sequencer
`include "sarseq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sarseq_top_bench;
	logic        mclk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic        rc_clk_pin = 1'b0, sleep_pin = 1'b0, comparator_pin = 1'b0;
	logic [4:0]  avs_address = 5'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic        avs_waitrequest, conversion_irq, wake_request;
	logic [1:0]  avs_response, resp;
	logic [7:0]  result_high_byte, result_low_byte;
	logic [4:0]  chans [5] = '{5'h00, `SARSEQ_CHAN_LASTPIN, `SARSEQ_CHAN_TEMP, `SARSEQ_CHAN_DAC, `SARSEQ_CHAN_FIXED};
	sarseq_pkg::sarseq_analog_s analog_ctrl;
	int          miscompares = 0, n_checks = 0, cyc = 0, t0, exp_t;
	// 200 us of settling at 100 MHz for the temperature channel
	localparam int temp_settle = 20000;
	sarseq_top DUT (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .rc_clk_pin(rc_clk_pin),
		.sleep_pin(sleep_pin), .comparator_pin(comparator_pin), .result_high_byte(result_high_byte),
		.result_low_byte(result_low_byte), .conversion_irq(conversion_irq), .wake_request(wake_request),
		.analog_ctrl(analog_ctrl));
	always #5 mclk = ~mclk;
	// odd half period keeps the rc source out of step with mclk
	always #37 rc_clk_pin = ~rc_clk_pin;
	always @(posedge mclk) cyc <= cyc + 1;
	////////////////////////////////////////////////////////////////
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("unexpected %s exp %h got %h", s, e, g);
			miscompares++;
		end
	endtask : chk
	// request held until the rising edge that sees waitrequest low; data taken and request dropped there
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		resp = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic conv_wait;
		do bus(1'b0, 5'h0, 32'h0); while (q[1] !== 1'b0 && cyc - t0 < 3000);
		chk("start bit", 32'h0, {31'h0, q[1]});
	endtask : conv_wait
	task automatic chk_res(input logic j, input logic c);
		logic [15:0] v;
		v = j ? {6'h0, {10{c}}} : {{10{c}}, 6'h0};
		chk("result high", {24'h0, v[15:8]}, {24'h0, result_high_byte});
		chk("result low", {24'h0, v[7:0]}, {24'h0, result_low_byte});
	endtask : chk_res
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////
	initial begin
		#700000;
		miscompares++;
		final_report();
	end
	initial begin
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		for (int a = 0; a < 5; a++) begin
			bus(1'b0, 5'(a * 4), 32'h0);
			chk("reset value", 32'h0, q);
		end
		bus(1'b0, 5'h18, 32'h0);
		chk("unmapped data", 32'h0, q);
		chk("unmapped response", 32'h2, {30'h0, resp});
		bus(1'b1, 5'h0, 32'h1);
		for (int p = 0; p < 8; p++) begin
			bus(1'b1, 5'h4, {29'h0, p[2:0]});
			@(negedge mclk);
			chk("pos ref", {30'h0, p[1:0]}, {30'h0, analog_ctrl.pos_ref_route});
			chk("neg ref", {31'h0, p[2]}, {31'h0, analog_ctrl.neg_ref_route});
		end
		foreach (chans[i]) begin
			bus(1'b1, 5'h0, {25'h0, chans[i], 2'b01});
			@(negedge mclk);
			chk("channel", {27'h0, chans[i]}, {27'h0, analog_ctrl.mux_route});
			chk("temp route", {31'h0, chans[i] == `SARSEQ_CHAN_TEMP}, {31'h0, analog_ctrl.temp_route});
		end
		bus(1'b1, 5'h0, 32'h2);
		repeat (40) @(posedge mclk);
		bus(1'b0, 5'h0, 32'h0);
		chk("start while off", 32'h0, q);
		bus(1'b0, 5'h10, 32'h0);
		chk("no flag while off", 32'h0, q);
		for (int c = 0; c < 8; c++) begin
			comparator_pin <= c[0];
			bus(1'b1, 5'h4, {24'h0, c[2], c[2:0], 4'h0});
			bus(1'b1, 5'h0, 32'h1);
			bus(1'b1, 5'h0, 32'h3);
			t0 = cyc;
			conv_wait();
			exp_t = 23 << (2 * c[1:0] + c[2]);
			if (c[1:0] != 2'b11) chk("cycles ok", 32'h1, {31'h0, (cyc - t0 + 2 >= exp_t) && (cyc - t0 <= exp_t + 16)});
			chk_res(c[2], c[0]);
			bus(1'b0, 5'h10, 32'h0);
			chk("done flag", 32'h1, q);
			chk("irq masked", 32'h0, {31'h0, conversion_irq});
			bus(1'b1, 5'h10, 32'h0);
		end
		bus(1'b1, 5'h0, {25'h0, `SARSEQ_CHAN_TEMP, 2'b01});
		repeat (temp_settle) @(posedge mclk);
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, 5'h0, {25'h0, `SARSEQ_CHAN_TEMP, 2'b11});
			t0 = cyc;
			conv_wait();
			chk("temp route", 32'h1, {31'h0, analog_ctrl.temp_route});
			chk_res(1'b1, 1'b1);
			if (k == 0) repeat (temp_settle) @(posedge mclk);
		end
		// low comparator: decided bits are zero, so a copied trial one would show
		comparator_pin <= 1'b0;
		bus(1'b1, 5'h4, 32'h60);
		bus(1'b1, 5'h0, 32'h3);
		repeat (200) @(posedge mclk);
		bus(1'b1, 5'h0, 32'h1);
		repeat (4) @(posedge mclk);
		bus(1'b0, 5'h8, 32'h0);
		chk("partial high", 32'h00, q);
		bus(1'b0, 5'hc, 32'h0);
		chk("partial low", 32'h00, q);
		bus(1'b1, 5'h0, 32'h3);
		repeat (100) @(posedge mclk);
		sleep_pin <= 1'b1;
		repeat (20) @(posedge mclk);
		bus(1'b0, 5'h14, 32'h0);
		chk("off in sleep", 32'h1, {31'h0, q[3]});
		bus(1'b0, 5'h0, 32'h0);
		chk("enable kept", 32'h1, {31'h0, q[0]});
		chk("powered off", 32'h0, {31'h0, analog_ctrl.powered});
		sleep_pin <= 1'b0;
		bus(1'b1, 5'h0, 32'h1);
		bus(1'b1, 5'h10, 32'h2);
		comparator_pin <= 1'b1;
		bus(1'b1, 5'h4, 32'hb0);
		bus(1'b1, 5'h0, 32'h3);
		sleep_pin <= 1'b1;
		t0 = cyc;
		while (wake_request !== 1'b1 && cyc - t0 < 3000) @(negedge mclk);
		chk("wake", 32'h1, {31'h0, wake_request});
		chk_res(1'b1, 1'b1);
		repeat (50) @(posedge mclk);
		chk("irq held", 32'h1, {31'h0, conversion_irq});
		sleep_pin <= 1'b0;
		bus(1'b1, 5'h10, 32'h2);
		@(negedge mclk);
		chk("irq cleared", 32'h0, {31'h0, conversion_irq});
		final_report();
	end
endmodule : sarseq_top_bench
`default_nettype wire

// ---- verif/sarseq_top_properties.sv ----
// port-level checks on the sar converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sarseq_props (
	input wire logic        mclk,
	input wire logic        reset,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [1:0]  avs_response,
	input wire logic [7:0]  result_high_byte,
	input wire logic [7:0]  result_low_byte,
	input wire logic        conversion_irq,
	input wire logic        wake_request
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	logic req;
	logic mapped;
	assign req = avs_read | avs_write;
	assign mapped = (avs_address[1:0] == 2'h0) && (avs_address <= 5'h14);
	a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
		else $error("first request cycle not stalled");
	a_wait_once: assert property (req && avs_waitrequest ##1 req |-> !avs_waitrequest)
		else $error("more than one wait state");
	a_idle_nowait: assert property (!req |-> !avs_waitrequest)
		else $error("wait raised while idle");
	a_unmapped_read: assert property (avs_read && !avs_waitrequest && !mapped |-> avs_response == 2'h2 && avs_readdata == 32'h0)
		else $error("unmapped read answered");
	a_mapped_ok: assert property (req && !avs_waitrequest && mapped |-> avs_response == 2'h0)
		else $error("mapped access refused");
	a_ctrl0_pad: assert property (avs_read && !avs_waitrequest && avs_address == 5'h0 |-> avs_readdata[31:7] == 25'h0)
		else $error("control zero unused bits set");
	a_justify_zero: assert property ((result_high_byte[7:2] == 6'h0) || (result_low_byte[5:0] == 6'h0))
		else $error("justified padding not zero");
	a_irq_swclear: assert property ($fell(conversion_irq) |-> $past(avs_write && !avs_waitrequest))
		else $error("interrupt dropped without a write");
	a_wake_irq: assert property (wake_request |-> conversion_irq)
		else $error("wake without interrupt");
endmodule : sarseq_props
bind sarseq_top sarseq_props u_props (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.avs_response(avs_response), .result_high_byte(result_high_byte), .result_low_byte(result_low_byte),
	.conversion_irq(conversion_irq), .wake_request(wake_request));
`default_nettype wire

// ---- verilog/sarseq_consts.svh ----
// constant definitions for the sar converter sequencer
`ifndef SARSEQ_CONSTS_SVH
`define SARSEQ_CONSTS_SVH
`define SARSEQ_OFS_CTRL0   4'h0
`define SARSEQ_OFS_CTRL1   4'h4
`define SARSEQ_OFS_RESH    4'h8
`define SARSEQ_OFS_RESL    4'hc
`define SARSEQ_OFS_FLAGS   5'h10
`define SARSEQ_OFS_SYS     5'h14
`define SARSEQ_CHAN_TEMP   5'h1d
`define SARSEQ_CHAN_DAC    5'h1e
`define SARSEQ_CHAN_FIXED  5'h1f
`define SARSEQ_CHAN_LASTPIN 5'h0b
`define SARSEQ_BITS        4'ha
`define SARSEQ_RC_HALF     8'h04
`define SARSEQ_RC_START_WAIT 8'h02
`define SARSEQ_PERIODS_X2  5'h17
`endif

// ---- verilog/sarseq_pkg.sv ----
// types for the sar converter sequencer
package sarseq_pkg;
	typedef enum logic [1:0] {
		SARSEQ_IDLE,
		SARSEQ_WAIT,
		SARSEQ_CONV
	} sarseq_state_e;
	typedef struct packed {
		logic [4:0] input_channel_select;
		logic       start_status;
		logic       converter_enable;
	} sarseq_ctrl0_s;
	typedef struct packed {
		logic       result_justify_select;
		logic [2:0] conversion_clock_select;
		logic       negative_ref_select;
		logic [1:0] positive_ref_select;
	} sarseq_ctrl1_s;
	typedef struct packed {
		logic [1:0] pos_ref_route;
		logic       neg_ref_route;
		logic [4:0] mux_route;
		logic       temp_route;
		logic       sample_hold;
		logic       powered;
	} sarseq_analog_s;
endpackage : sarseq_pkg

// ---- verilog/sarseq_top.sv ----
// sar converter sequencer: avalon registers, clock divider, bit sequencing
//
// Contract
// - produce a 10-bit result by successive approximation into the result pair.
// - channel field picks one of 15 inputs for the sample-and-hold.
// - positive reference picks external pin, supply, or fixed reference levels.
// - negative reference bit picks external pin or ground.
// - clock field: system clock /2../64 by the listed codes, x11 is rc oscillator.
// - a full conversion takes 11.5 bit-conversion periods.
// - divider clocks come from the system clock; only rc is independent.
// - done flag sets on every completion, enable or not.
// - interrupt request when done flag and its enable are both set.
// - conversions continue in sleep only on the rc clock.
// - an interrupt request raised during sleep wakes the device.
// - justify bit places the result left or right in the pair.
// - set the enable bit, then writing one to start begins a conversion.
// - one channel code routes the temperature indicator to the converter.
// - on completion clear start, set done flag, load result pair.
// - clearing start mid-conversion loads partial result, rest copy last bit.
// - right justify zeroes upper six high bits; left zeroes lower six low bits.
// - sleep on a divider clock aborts and powers off; enable stays set.
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`include "sarseq_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module sarseq_top (
	input  wire logic                    mclk,
	input  wire logic                    reset,
	input  wire logic [4:0]              avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [31:0]             avs_writedata,
	input  wire logic [3:0]              avs_byteenable,
	output logic      [31:0]             avs_readdata,
	output logic                         avs_waitrequest,
	output logic      [1:0]              avs_response,
	input  wire logic                    rc_clk_pin,
	input  wire logic                    sleep_pin,
	input  wire logic                    comparator_pin,
	output logic      [7:0]              result_high_byte,
	output logic      [7:0]              result_low_byte,
	output logic                         conversion_irq,
	output logic                         wake_request,
	output sarseq_pkg::sarseq_analog_s   analog_ctrl
);
	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; first stage feeds only the second
	logic [2:0] sync1_r, sync2_r, rc_prev_r;
	always_ff @(posedge mclk) begin
		sync1_r   <= reset ? 3'h0 : {rc_clk_pin, sleep_pin, comparator_pin};
		sync2_r   <= reset ? 3'h0 : sync1_r;
		rc_prev_r <= reset ? 3'h0 : sync2_r;
	end
	wire rc_rise = sync2_r[2] & ~rc_prev_r[2];
	wire asleep  = sync2_r[1];
	wire cmp_hi  = sync2_r[0];

	////////////////////////////////////////////////////////////////////////////////
	// registers and sequencer state
	sarseq_pkg::sarseq_ctrl0_s ctrl0_r, ctrl0_nxt;
	sarseq_pkg::sarseq_ctrl1_s ctrl1_r, ctrl1_nxt;
	sarseq_pkg::sarseq_state_e state_r, state_nxt;
	logic [7:0] resh_r, resh_nxt, resl_r, resl_nxt;
	logic       flag_r, flag_nxt, irqen_r, irqen_nxt, off_r, off_nxt;
	logic [5:0] div_r, div_nxt;
	logic [4:0] half_r, half_nxt;
	logic [7:0] wait_r, wait_nxt;
	logic [9:0] sar_r, sar_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic       ack_r, ack_nxt;

	// local names for the package states; nothing is imported
	localparam sarseq_pkg::sarseq_state_e SARSEQ_IDLE = sarseq_pkg::SARSEQ_IDLE;
	localparam sarseq_pkg::sarseq_state_e SARSEQ_WAIT = sarseq_pkg::SARSEQ_WAIT;
	localparam sarseq_pkg::sarseq_state_e SARSEQ_CONV = sarseq_pkg::SARSEQ_CONV;

	// divider terminal count in system clocks for each code
	function automatic logic [5:0] div_top(input logic [2:0] sel);
		case (sel)
			3'h0: div_top = 6'h00;
			3'h4: div_top = 6'h01;
			3'h1: div_top = 6'h03;
			3'h5: div_top = 6'h07;
			3'h2: div_top = 6'h0f;
			3'h6: div_top = 6'h1f;
			default: div_top = 6'h00;
		endcase
	endfunction

	// format 10 bits into the register pair
	function automatic logic [15:0] justify(input logic [9:0] v, input logic right);
		justify = right ? {6'h00, v} : {v, 6'h00};
	endfunction

	wire is_rc    = (ctrl1_r.conversion_clock_select[1:0] == 2'h3);
	wire half_tick;
	// rc is independent of mclk timing; dividers follow the system clock
	assign half_tick = is_rc ? rc_rise : (div_r == div_top(ctrl1_r.conversion_clock_select));

	wire [4:0] a_idx = avs_address;
	// writes land on the acknowledged cycle, at the edge where waitrequest is low
	wire wr_ctrl0 = avs_write & ack_r & (a_idx == 5'(`SARSEQ_OFS_CTRL0)) & avs_byteenable[0];
	wire wr_ctrl1 = avs_write & ack_r & (a_idx == 5'(`SARSEQ_OFS_CTRL1)) & avs_byteenable[0];
	wire wr_flags = avs_write & ack_r & (a_idx == `SARSEQ_OFS_FLAGS) & avs_byteenable[0];
	wire [7:0] wd = avs_writedata[7:0];

	always_comb begin
		logic [15:0] packed_res;
		logic        done;
		logic        abort;
		packed_res = 16'h0000;
		done      = 1'b0;
		abort     = 1'b0;
		ctrl0_nxt = ctrl0_r;
		ctrl1_nxt = ctrl1_r;
		state_nxt = state_r;
		resh_nxt  = resh_r;
		resl_nxt  = resl_r;
		flag_nxt  = flag_r;
		irqen_nxt = irqen_r;
		off_nxt   = off_r;
		div_nxt   = half_tick ? 6'h00 : div_r + 6'h01;
		half_nxt  = half_r;
		wait_nxt  = wait_r;
		sar_nxt   = sar_r;
		bit_nxt   = bit_r;
		ack_nxt   = (avs_read | avs_write) & ~ack_r;
		if (wr_ctrl1)
			ctrl1_nxt = sarseq_pkg::sarseq_ctrl1_s'({wd[7:4], wd[2:0]});
		if (wr_flags) begin
			flag_nxt  = wd[0];
			irqen_nxt = wd[1];
		end
		if (wr_ctrl0) begin
			ctrl0_nxt.input_channel_select = wd[6:2];
			ctrl0_nxt.converter_enable     = wd[0];
			ctrl0_nxt.start_status         = wd[1] & wd[0];
			if (wd[0])
				off_nxt = 1'b0;
		end
		case (state_r)
			SARSEQ_IDLE: begin
				if (ctrl0_nxt.start_status & ~off_r) begin
					state_nxt = is_rc ? SARSEQ_WAIT : SARSEQ_CONV;
					wait_nxt  = `SARSEQ_RC_START_WAIT;
					half_nxt  = 5'h00;
					div_nxt   = 6'h00;
					sar_nxt   = 10'h200;
					bit_nxt   = `SARSEQ_BITS - 4'h1;
				end
			end
			SARSEQ_WAIT: begin
				// rc start waits a little so a sleep entry settles first
				if (rc_rise)
					wait_nxt = wait_r - 8'h01;
				if (wait_r == 8'h00)
					state_nxt = SARSEQ_CONV;
				if (!ctrl0_nxt.start_status)
					state_nxt = SARSEQ_IDLE;
			end
			SARSEQ_CONV: begin
				// half periods give the 11.5 period total; bit decisions on odd halves
				if (half_tick) begin
					half_nxt = half_r + 5'h01;
					if (half_r >= 5'h03 && half_r[0] && half_r < 5'h16) begin
						if (!cmp_hi)
							sar_nxt[bit_r] = 1'b0;
						if (bit_r != 4'h0) begin
							sar_nxt[bit_r - 4'h1] = 1'b1;
							bit_nxt = bit_r - 4'h1;
						end
					end
					if (half_r == `SARSEQ_PERIODS_X2 - 5'h01)
						done = 1'b1;
				end
				if (!ctrl0_nxt.start_status) begin
					done = 1'b0;
					abort = 1'b1;
				end
			end
			default: state_nxt = SARSEQ_IDLE;
		endcase
		// sleep on a divider clock aborts and powers down; enable bit kept
		if (asleep && !is_rc && state_r != SARSEQ_IDLE) begin
			state_nxt = SARSEQ_IDLE;
			ctrl0_nxt.start_status = 1'b0;
			off_nxt = 1'b1;
			done  = 1'b0;
			abort = 1'b0;
		end
		if (done || (abort && state_r == SARSEQ_CONV)) begin
			// partial: the current bit and all bits below it copy the last decided bit
			if (abort) begin
				for (int i = 0; i < 10; i++)
					if (4'(i) < bit_r)
						sar_nxt[i] = sar_r[bit_r];
				sar_nxt[bit_r] = (bit_r == 4'h9) ? sar_r[bit_r] : sar_r[bit_r + 4'h1];
				for (int i = 0; i < 10; i++)
					if (4'(i) <= bit_r)
						sar_nxt[i] = (bit_r == 4'h9) ? 1'b0 : sar_r[bit_r + 4'h1];
			end
			packed_res = justify(sar_nxt, ctrl1_r.result_justify_select);
			resh_nxt  = packed_res[15:8];
			resl_nxt  = packed_res[7:0];
			state_nxt = SARSEQ_IDLE;
		end
		if (done) begin
			ctrl0_nxt.start_status = 1'b0;
			flag_nxt = 1'b1;
		end
		if (state_r == SARSEQ_IDLE && state_nxt == SARSEQ_IDLE)
			ctrl0_nxt.start_status = 1'b0;
		if (!ctrl0_nxt.converter_enable) begin
			state_nxt = SARSEQ_IDLE;
			ctrl0_nxt.start_status = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl0_r <= '0;
			ctrl1_r <= '0;
			state_r <= SARSEQ_IDLE;
			resh_r  <= 8'h00;
			resl_r  <= 8'h00;
			flag_r  <= 1'b0;
			irqen_r <= 1'b0;
			off_r   <= 1'b0;
			div_r   <= 6'h00;
			half_r  <= 5'h00;
			wait_r  <= 8'h00;
			sar_r   <= 10'h000;
			bit_r   <= 4'h0;
			ack_r   <= 1'b0;
		end else begin
			ctrl0_r <= ctrl0_nxt;
			ctrl1_r <= ctrl1_nxt;
			state_r <= state_nxt;
			resh_r  <= resh_nxt;
			resl_r  <= resl_nxt;
			flag_r  <= flag_nxt;
			irqen_r <= irqen_nxt;
			off_r   <= off_nxt;
			div_r   <= div_nxt;
			half_r  <= half_nxt;
			wait_r  <= wait_nxt;
			sar_r   <= sar_nxt;
			bit_r   <= bit_nxt;
			ack_r   <= ack_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus answer: one wait cycle, then ack
	always_comb begin
		case (a_idx)
			5'(`SARSEQ_OFS_CTRL0): avs_readdata = {25'h0, ctrl0_r.input_channel_select,
				ctrl0_r.start_status, ctrl0_r.converter_enable};
			5'(`SARSEQ_OFS_CTRL1): avs_readdata = {24'h0, ctrl1_r.result_justify_select,
				ctrl1_r.conversion_clock_select, 1'b0, ctrl1_r.negative_ref_select,
				ctrl1_r.positive_ref_select};
			5'(`SARSEQ_OFS_RESH):  avs_readdata = {24'h0, resh_r};
			5'(`SARSEQ_OFS_RESL):  avs_readdata = {24'h0, resl_r};
			`SARSEQ_OFS_FLAGS:     avs_readdata = {30'h0, irqen_r, flag_r};
			`SARSEQ_OFS_SYS:       avs_readdata = {28'h0, off_r, asleep, state_r != SARSEQ_IDLE, is_rc};
			default:               avs_readdata = 32'h0000_0000;
		endcase
	end
	wire mapped = (a_idx[1:0] == 2'h0) && (a_idx <= `SARSEQ_OFS_SYS);
	assign avs_waitrequest  = (avs_read | avs_write) & ~ack_r;
	assign avs_response     = mapped ? 2'h0 : 2'h2;
	assign result_high_byte = resh_r;
	assign result_low_byte  = resl_r;
	assign conversion_irq   = flag_r & irqen_r;
	assign wake_request     = flag_r & irqen_r & asleep;
	always_comb begin
		analog_ctrl.pos_ref_route = ctrl1_r.positive_ref_select;
		analog_ctrl.neg_ref_route = ctrl1_r.negative_ref_select;
		analog_ctrl.mux_route     = ctrl0_r.input_channel_select;
		analog_ctrl.temp_route    = (ctrl0_r.input_channel_select == `SARSEQ_CHAN_TEMP);
		analog_ctrl.sample_hold   = (state_r != SARSEQ_CONV);
		analog_ctrl.powered       = ctrl0_r.converter_enable & ~off_r;
	end
endmodule : sarseq_top
`default_nettype wire
